// *** rtl/uaf_addr_filter.sv ***
// Per-port receive qualification: decides if a finished frame completes reception.
// Assumes frame events arrive as one-cycle pulses on the block clock.
`timescale 1ns/100ps
module uaf_addr_filter
  import uaf_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  uaf_rx_if.filt    bus
);
  import uaf_pkg::*;

  logic acceptFf;
  logic ninthLoadFf;
  logic ninthFf;
  logic nxt_accept;
  logic nxt_ninthLoad;
  logic nxt_ninth;
  logic isAddr;
  logic hit;

  // ****************************************************************
  // Qualification
  // ****************************************************************
  always_comb begin
    nxt_accept    = 1'b0;
    nxt_ninthLoad = 1'b0;
    nxt_ninth     = ninthFf;
    isAddr        = bus.bit9;
    hit           = uafGivenMatch(bus.data, bus.addrValue, bus.addrMask) |
                    uafBcastMatch(bus.data, bus.addrValue, bus.addrMask);
    if (bus.frameValid) begin
      case (bus.mode)
        MODE_SHIFT: begin
          nxt_accept = 1'b1;
        end
        MODE_8VAR: begin
          nxt_accept    = ~bus.mpEnable | bus.stopOk;
          nxt_ninthLoad = nxt_accept;
          nxt_ninth     = bus.stopOk;
        end
        MODE_9FIX, MODE_9VAR: begin
          // Data frames are dropped while filtering; mismatched addresses too
          nxt_accept    = ~bus.mpEnable | (isAddr & hit);
          nxt_ninthLoad = nxt_accept;
          nxt_ninth     = bus.bit9;
        end
        default: begin
          nxt_accept = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acceptFf    <= 1'b0;
      ninthLoadFf <= 1'b0;
      ninthFf     <= 1'b0;
    end else begin
      acceptFf    <= nxt_accept;
      ninthLoadFf <= nxt_ninthLoad;
      ninthFf     <= nxt_ninth;
    end
  end

  assign bus.accept    = acceptFf;
  assign bus.ninthLoad = ninthLoadFf;
  assign bus.ninth     = ninthFf;

endmodule

// *** rtl/uaf_pkg.sv ***
// Shared constants, types and address-match helpers for the address filter.
// Assumes a single 200 MHz clock domain and classic Wishbone register access.
package uaf_pkg;

  // ****************************************************************
  // Structure
  // ****************************************************************
  localparam int PORTS = 2;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL [PORTS] = '{8'h00, 8'h0C};
  localparam logic [7:0] OFS_ADDR [PORTS] = '{8'h04, 8'h10};
  localparam logic [7:0] OFS_MASK [PORTS] = '{8'h08, 8'h14};
  localparam logic [7:0] OFS_INT_STAT = 8'h18;
  localparam logic [7:0] OFS_INT_MASK = 8'h1C;

  // ****************************************************************
  // serial_control field positions
  // ****************************************************************
  localparam int CTL_RX_DONE = 0;
  localparam int CTL_TX_DONE = 1;
  localparam int CTL_NINTH   = 2;
  localparam int CTL_RX_EN   = 4;
  localparam int CTL_MP_EN   = 5;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MODE_HI = 7;
  localparam logic [7:0] CTL_WR_MASK = 8'hF0;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  ADDR_RST     = 8'h00;
  localparam logic [7:0]  MASK_RST     = 8'h00;
  localparam logic [3:0]  INT_STAT_RST = 4'h0;
  localparam logic [3:0]  INT_MASK_RST = 4'h0;
  localparam logic [31:0] DAT_RST      = 32'h0000_0000;

  // ****************************************************************
  // Interrupt arbitration slots, one status bit per slot
  // ****************************************************************
  localparam int SLOT_FIRST  = 9;
  localparam int SLOT_P0_RX  = 9;
  localparam int SLOT_P0_TX  = 10;
  localparam int SLOT_P1_RX  = 11;
  localparam int SLOT_P1_TX  = 12;
  localparam int IRQ_BIT_RX [PORTS] = '{SLOT_P0_RX - SLOT_FIRST, SLOT_P1_RX - SLOT_FIRST};
  localparam int IRQ_BIT_TX [PORTS] = '{SLOT_P0_TX - SLOT_FIRST, SLOT_P1_TX - SLOT_FIRST};

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_8VAR  = 2'b01,
    MODE_9FIX  = 2'b10,
    MODE_9VAR  = 2'b11
  } uaf_mode_e;

  // ****************************************************************
  // Address match helpers
  // ****************************************************************
  function automatic logic uafGivenMatch(input logic [7:0] rx, input logic [7:0] addr,
                                         input logic [7:0] mask);
    return ((rx ^ addr) & mask) == 8'h00;
  endfunction

  function automatic logic uafBcastMatch(input logic [7:0] rx, input logic [7:0] addr,
                                         input logic [7:0] mask);
    return ((addr | mask) & ~rx) == 8'h00;
  endfunction

endpackage

// *** rtl/uaf_rx_if.sv ***
// Frame qualification handshake between the register block and a filter.
// Assumes both ends run on the same clock; no crossing inside.
`timescale 1ns/100ps
interface uaf_rx_if;
  import uaf_pkg::*;
  logic            frameValid;
  logic [7:0]      data;
  logic            bit9;
  logic            stopOk;
  uaf_mode_e       mode;
  logic            mpEnable;
  logic [7:0]      addrValue;
  logic [7:0]      addrMask;
  logic            accept;
  logic            ninthLoad;
  logic            ninth;

  modport ctrl (output frameValid, data, bit9, stopOk, mode, mpEnable, addrValue, addrMask,
                input  accept, ninthLoad, ninth);
  modport filt (input  frameValid, data, bit9, stopOk, mode, mpEnable, addrValue, addrMask,
                output accept, ninthLoad, ninth);
endinterface

// *** rtl/uaf_top.sv ***
// Dual-port serial receive qualification with address recognition and interrupts.
// Assumes frame and transmit events come from same-clock shifter logic, one-cycle
// pulses, and registers are reached over a classic Wishbone slave port.
`timescale 1ns/100ps

module uaf_top
  import uaf_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // Wishbone classic slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Receiver and transmitter events
  input  wire logic [uaf_pkg::PORTS-1:0] rxFrameValid,
  input  wire logic [7:0]               rxFrameData0,
  input  wire logic [7:0]               rxFrameData1,
  input  wire logic [uaf_pkg::PORTS-1:0] rxFrameBit9,
  input  wire logic [uaf_pkg::PORTS-1:0] rxFrameStopOk,
  input  wire logic [uaf_pkg::PORTS-1:0] txDone,
  // Interrupts
  output logic      [3:0]               irqReq,
  output logic                          irq
);
  import uaf_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]  ctrl_ff      [PORTS];
  logic [7:0]  addrValue_ff [PORTS];
  logic [7:0]  addrMask_ff  [PORTS];
  logic [3:0]  intStat_ff;
  logic [3:0]  intMask_ff;
  logic        ack_ff;
  logic [31:0] datOut_ff;
  logic [3:0]  irqReq_ff;
  logic        irq_ff;

  logic [7:0]  nxt_ctrl      [PORTS];
  logic [7:0]  nxt_addrValue [PORTS];
  logic [7:0]  nxt_addrMask  [PORTS];
  logic [3:0]  nxt_intStat;
  logic [3:0]  nxt_intMask;
  logic        nxt_ack;
  logic [31:0] nxt_datOut;
  logic [3:0]  nxt_irqReq;
  logic        nxt_irq;

  logic [PORTS-1:0] filtAccept;
  logic [PORTS-1:0] filtNinthLoad;
  logic [PORTS-1:0] filtNinth;
  logic [7:0]       rxData [PORTS];

  logic        wbReq;
  logic        wrStrobe;
  logic [3:0]  intSet;
  logic [3:0]  intClr;
  logic [1:0]  flagClr;
  logic [7:0]  rdByte;

  assign rxData[0] = rxFrameData0;
  assign rxData[1] = rxFrameData1;

  // ****************************************************************
  // Per-port filters
  // ****************************************************************
  uaf_rx_if rxIf [PORTS] ();

  for (genvar g = 0; g < PORTS; g++) begin : gPort
    assign rxIf[g].frameValid = rxFrameValid[g] & ctrl_ff[g][CTL_RX_EN];
    assign rxIf[g].data       = rxData[g];
    assign rxIf[g].bit9       = rxFrameBit9[g];
    assign rxIf[g].stopOk     = rxFrameStopOk[g];
    assign rxIf[g].mode       = uaf_mode_e'(ctrl_ff[g][CTL_MODE_HI:CTL_MODE_LO]);
    assign rxIf[g].mpEnable   = ctrl_ff[g][CTL_MP_EN];
    assign rxIf[g].addrValue  = addrValue_ff[g];
    assign rxIf[g].addrMask   = addrMask_ff[g];
    assign filtAccept[g]      = rxIf[g].accept;
    assign filtNinthLoad[g]   = rxIf[g].ninthLoad;
    assign filtNinth[g]       = rxIf[g].ninth;

    uaf_addr_filter uFilter (
      .clk    (clk),
      .arst_n (arst_n),
      .bus    (rxIf[g])
    );
  end

  // ****************************************************************
  // Register bus and flag update
  // ****************************************************************
  // Write commits on the edge that the master sees ack, so one request
  // never writes twice even if the master holds strobe a cycle longer.
  always_comb begin
    wbReq    = wb_cyc_i & wb_stb_i;
    wrStrobe = wbReq & wb_we_i & ack_ff & wb_sel_i[0];
    nxt_ack  = wbReq & ~ack_ff;

    nxt_ctrl      = ctrl_ff;
    nxt_addrValue = addrValue_ff;
    nxt_addrMask  = addrMask_ff;
    nxt_intMask   = intMask_ff;
    intSet        = 4'h0;
    intClr        = 4'h0;
    flagClr       = 2'b00;
    rdByte        = 8'h00;

    for (int p = 0; p < PORTS; p++) begin
      flagClr = 2'b00;
      if (wrStrobe && wb_adr_i == OFS_CTRL[p]) begin
        nxt_ctrl[p] = (ctrl_ff[p] & ~CTL_WR_MASK) | (wb_dat_i[7:0] & CTL_WR_MASK);
        flagClr     = wb_dat_i[CTL_TX_DONE:CTL_RX_DONE];
      end
      if (wrStrobe && wb_adr_i == OFS_ADDR[p]) begin
        nxt_addrValue[p] = wb_dat_i[7:0];
      end
      if (wrStrobe && wb_adr_i == OFS_MASK[p]) begin
        nxt_addrMask[p] = wb_dat_i[7:0];
      end
      // Hardware set wins over a software clear in the same cycle
      nxt_ctrl[p][CTL_RX_DONE] = (ctrl_ff[p][CTL_RX_DONE] & ~flagClr[0]) | filtAccept[p];
      nxt_ctrl[p][CTL_TX_DONE] = (ctrl_ff[p][CTL_TX_DONE] & ~flagClr[1]) | txDone[p];
      if (filtNinthLoad[p]) begin
        nxt_ctrl[p][CTL_NINTH] = filtNinth[p];
      end
      intSet[IRQ_BIT_RX[p]] = filtAccept[p];
      intSet[IRQ_BIT_TX[p]] = txDone[p];
      if (wb_adr_i == OFS_CTRL[p]) begin
        rdByte = ctrl_ff[p];
      end
      if (wb_adr_i == OFS_ADDR[p]) begin
        rdByte = addrValue_ff[p];
      end
      if (wb_adr_i == OFS_MASK[p]) begin
        rdByte = addrMask_ff[p];
      end
    end

    if (wrStrobe && wb_adr_i == OFS_INT_STAT) begin
      intClr = wb_dat_i[3:0];
    end
    if (wrStrobe && wb_adr_i == OFS_INT_MASK) begin
      nxt_intMask = wb_dat_i[3:0];
    end
    if (wb_adr_i == OFS_INT_STAT) begin
      rdByte = {4'h0, intStat_ff};
    end
    if (wb_adr_i == OFS_INT_MASK) begin
      rdByte = {4'h0, intMask_ff};
    end

    nxt_intStat = (intStat_ff & ~intClr) | intSet;

    // Unmapped addresses read zero and still get an ack
    nxt_datOut = datOut_ff;
    if (wbReq & ~ack_ff) begin
      nxt_datOut = {24'h000000, rdByte};
    end

    nxt_irqReq = intStat_ff & intMask_ff;
    nxt_irq    = |(intStat_ff & intMask_ff);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < PORTS; p++) begin
        ctrl_ff[p]      <= CTRL_RST;
        addrValue_ff[p] <= ADDR_RST;
        addrMask_ff[p]  <= MASK_RST;
      end
      intStat_ff <= INT_STAT_RST;
      intMask_ff <= INT_MASK_RST;
      ack_ff     <= 1'b0;
      datOut_ff  <= DAT_RST;
      irqReq_ff  <= INT_STAT_RST;
      irq_ff     <= 1'b0;
    end else begin
      ctrl_ff      <= nxt_ctrl;
      addrValue_ff <= nxt_addrValue;
      addrMask_ff  <= nxt_addrMask;
      intStat_ff   <= nxt_intStat;
      intMask_ff   <= nxt_intMask;
      ack_ff       <= nxt_ack;
      datOut_ff    <= nxt_datOut;
      irqReq_ff    <= nxt_irqReq;
      irq_ff       <= nxt_irq;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wb_dat_o = datOut_ff;
  assign wb_ack_o = ack_ff;
  assign irqReq   = irqReq_ff;
  assign irq      = irq_ff;

endmodule

// *** testbench/uaf_serial_master.sv ***
// Model of the serial front end: finished frames and transmit-done pulses.
// Assumes the bench calls one task at a time, on the block clock.
`timescale 1ns/100ps
module uaf_serial_master
  import uaf_pkg::*;
(
  input  wire logic                 clk,
  output logic [uaf_pkg::PORTS-1:0] rxFrameValid,
  output logic [7:0]                rxFrameData0,
  output logic [7:0]                rxFrameData1,
  output logic [uaf_pkg::PORTS-1:0] rxFrameBit9,
  output logic [uaf_pkg::PORTS-1:0] rxFrameStopOk,
  output logic [uaf_pkg::PORTS-1:0] txDone
);
  initial begin
    rxFrameValid = '0;
    rxFrameData0 = 8'h00;
    rxFrameData1 = 8'h00;
    rxFrameBit9 = '0;
    rxFrameStopOk = '0;
    txDone = '0;
  end
  // ****
  // Frame and transmit events
  // ****
  // Address frames carry ninth bit one, data frames zero
  task send(input int p, input logic [7:0] d, input logic isAddr, input logic st);
    @(posedge clk);
    rxFrameValid[p] <= 1'b1;
    if (p == 0)
      rxFrameData0 <= d;
    else
      rxFrameData1 <= d;
    rxFrameBit9[p] <= isAddr;
    rxFrameStopOk[p] <= st;
    @(posedge clk);
    rxFrameValid <= '0;
    // Lines toggle when idle so a stale value never passes as valid
    rxFrameData0 <= ~rxFrameData0;
    rxFrameData1 <= ~rxFrameData1;
    rxFrameBit9 <= ~rxFrameBit9;
    rxFrameStopOk <= ~rxFrameStopOk;
  endtask
  task tx(input int p);
    @(posedge clk);
    txDone[p] <= 1'b1;
    @(posedge clk);
    txDone <= '0;
  endtask
endmodule

// *** testbench/uaf_top_monitor.sv ***
// Port checker for the dual-port address filter top.
// Assumes a bind to every uaf_top; one clock, async reset.
`timescale 1ns/100ps
module uaf_top_monitor
  import uaf_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      arst_n,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [31:0]               wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire logic [uaf_pkg::PORTS-1:0] rxFrameValid,
  input wire logic [uaf_pkg::PORTS-1:0] txDone,
  input wire logic [3:0]                irqReq,
  input wire logic                      irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ****
  // Bus and interrupt relations
  // ****
  property p_ack_next; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("read data high bits set");
  property p_irq_or; irq == |irqReq; endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not OR of requests");
  // Only a register write may lower the line
  property p_irq_fall; $fell(irq) |-> $past(wb_cyc_i && wb_we_i, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  property p_irq_hold; (irq && !wb_cyc_i && !$past(wb_cyc_i)) |=> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_rx0_rise;
    $rose(irqReq[0]) |-> $past(rxFrameValid[0], 3) || $past(rxFrameValid[0], 4)
                         || $past(wb_cyc_i && wb_we_i, 2);
  endproperty
  a_rx0_rise: assert property (p_rx0_rise) else $error("slot 9 without cause");
  property p_tx1_rise;
    $rose(irqReq[3]) |-> $past(txDone[1], 2) || $past(txDone[1], 3)
                         || $past(wb_cyc_i && wb_we_i, 2);
  endproperty
  a_tx1_rise: assert property (p_tx1_rise) else $error("slot 12 without cause");
endmodule

bind uaf_top uaf_top_monitor u_uaf_top_monitor (.clk(clk), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rxFrameValid(rxFrameValid), .txDone(txDone), .irqReq(irqReq),
  .irq(irq));

// *** testbench/uaf_top_tb_top.sv ***
// Self-checking bench for the address filter top.
// Assumes the port checker is bound in from its own file.
`timescale 1ns/100ps
module uaf_top_tb_top;
  import uaf_pkg::*;
  localparam logic [9:0] FR [5] = '{10'h30B, 10'h307, 10'h3FE, 10'h300, 10'h306};
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic [1:0]  frV, frB9, frStop, txD;
  logic [7:0]  frD0, frD1;
  logic [3:0]  irqReq;
  logic        irq;
  int          fails = 0;
  int          checksDone = 0;
  always #2.5 clk = ~clk;
  uaf_top u_uaf_top (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .rxFrameValid(frV), .rxFrameData0(frD0), .rxFrameData1(frD1),
    .rxFrameBit9(frB9), .rxFrameStopOk(frStop), .txDone(txD), .irqReq(irqReq), .irq(irq));
  uaf_serial_master u_uaf_serial_master (.clk(clk), .rxFrameValid(frV), .rxFrameData0(frD0),
    .rxFrameData1(frD1), .rxFrameBit9(frB9), .rxFrameStopOk(frStop), .txDone(txD));
  // ****
  // Tasks
  // ****
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'hF;
    wbDatI <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 40);
    r = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    if (n >= 40)
      check("ackWait", 32'h0, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    wb(1'b0, a, 32'h0, d);
  endtask
  // Filter set to addr C0, mask FD while this is used
  function automatic logic expAcc(input logic [1:0] m, input logic e, input logic [9:0] f);
    logic g, b;
    g = (f[9:2] & 8'hFD) == 8'hC0;
    b = (f[9:2] & 8'hFD) == 8'hFD;
    case (m)
      2'h0: return 1'b1;
      2'h1: return !e || f[0];
      default: return !e || (f[1] && (g || b));
    endcase
  endfunction
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end
  // ****
  // Tests
  // ****
  initial begin
    logic [31:0] v;
    logic [7:0]  c;
    logic        x, nin;
    nin = 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      rd(8'(k * 4), v);
      check("resetReg", v, 32'h0);
    end
    wr(OFS_CTRL[0], 32'hF0);
    u_uaf_serial_master.send(0, 8'h5A, 1'b1, 1'b1);
    repeat (3) @(posedge clk);
    rd(OFS_CTRL[0], v);
    check("openFilter", v, 32'hF5);
    $display("Test reset defaults done");
    wr(OFS_ADDR[0], 32'hC0);
    wr(OFS_MASK[0], 32'hFD);
    rd(OFS_ADDR[0], v);
    check("slaveAddr", v, 32'hC0);
    rd(OFS_MASK[0], v);
    check("slaveMask", v, 32'hFD);
    for (int m = 0; m < 4; m++) begin
      for (int e = 0; e < 2; e++) begin
        for (int i = 0; i < 5; i++) begin
          c = {m[1:0], e[0], 5'h13};
          wr(OFS_CTRL[0], {24'h0, c});
          wr(OFS_INT_STAT, 32'hF);
          u_uaf_serial_master.send(0, FR[i][9:2], FR[i][1], FR[i][0]);
          repeat (3) @(posedge clk);
          x = expAcc(m[1:0], e[0], FR[i]);
          if (x && m != 0)
            nin = (m == 1) ? FR[i][0] : FR[i][1];
          rd(OFS_CTRL[0], v);
          check("ctrlMode", v[7:4], c[7:4]);
          check("rxDone", v[0], x);
          if (m != 0)
            check("ninthBit", v[2], nin);
          rd(OFS_INT_STAT, v);
          check("rxStat", v[0], x);
        end
      end
    end
    $display("Test mode and address filter done");
    wr(OFS_INT_STAT, 32'hF);
    wr(OFS_CTRL[1], 32'h10);
    wr(OFS_INT_MASK, 32'h5);
    u_uaf_serial_master.tx(0);
    u_uaf_serial_master.send(1, 8'h33, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    check("irqReqRx1", irqReq, 4'h4);
    check("irqLine", irq, 1'b1);
    u_uaf_serial_master.tx(1);
    repeat (4) @(posedge clk);
    rd(OFS_INT_STAT, v);
    check("intStat", v, 32'hE);
    wr(OFS_INT_MASK, 32'hF);
    repeat (3) @(posedge clk);
    check("irqReqAll", irqReq, 4'hE);
    wr(OFS_INT_STAT, 32'hE);
    repeat (3) @(posedge clk);
    check("irqClear", {irqReq, irq}, 5'h00);
    // Port 0 still filters on C0/FD in mode 3; C2 is a given match
    u_uaf_serial_master.send(0, 8'hC2, 1'b1, 1'b1);
    u_uaf_serial_master.tx(1);
    repeat (4) @(posedge clk);
    check("irqReqLate", irqReq, 4'h9);
    check("irqLineLate", irq, 1'b1);
    wr(OFS_INT_STAT, 32'h9);
    repeat (3) @(posedge clk);
    check("irqDone", {irqReq, irq}, 5'h00);
    $display("Test interrupts done");
    // ****
    // Second port filter and receive enable
    // ****
    wr(OFS_ADDR[1], 32'h12);
    wr(OFS_MASK[1], 32'hFF);
    wr(OFS_CTRL[1], 32'hB3);
    u_uaf_serial_master.send(1, 8'h13, 1'b1, 1'b1);
    repeat (3) @(posedge clk);
    rd(OFS_INT_STAT, v);
    check("p1Reject", v, 32'h0);
    rd(OFS_CTRL[1], v);
    check("p1RejCtrl", v, 32'hB0);
    u_uaf_serial_master.send(1, 8'h12, 1'b1, 1'b1);
    repeat (3) @(posedge clk);
    rd(OFS_INT_STAT, v);
    check("p1Accept", v, 32'h4);
    rd(OFS_CTRL[1], v);
    check("p1AccCtrl", v, 32'hB5);
    wr(OFS_CTRL[1], 32'h03);
    wr(OFS_INT_STAT, 32'hF);
    u_uaf_serial_master.send(1, 8'h12, 1'b1, 1'b1);
    repeat (3) @(posedge clk);
    rd(OFS_INT_STAT, v);
    check("p1Disabled", v, 32'h0);
    $display("Test port 1 filter done");
    final_report();
  end
endmodule
